/* File: common/timer0_defs.vh */
// Register map, field positions, reset values and timing counts of the timer block
`ifndef TIMER0_DEFS_VH
`define TIMER0_DEFS_VH

// Register indices as printed; byte address is four times the index
`define IDX_TIMER_COUNT 8'h01
`define IDX_INTERRUPT_CONTROL 8'h0b
`define IDX_TIMER_CONFIGURATION 8'h81
`define IDX_CORE_CONTROL 8'h90
`define ADDR_TIMER_COUNT 12'h004
`define ADDR_INTERRUPT_CONTROL 12'h02c
`define ADDR_TIMER_CONFIGURATION 12'h204
`define ADDR_CORE_CONTROL 12'h240

// Configuration register fields
`define CFG_CLOCK_SOURCE_SELECT 5
`define CFG_SOURCE_EDGE_SELECT 4
`define CFG_PRESCALER_ASSIGNMENT 3
`define CFG_RATIO_HI 2
`define CFG_RATIO_LO 0
`define CFG_RESET 8'hff

// Interrupt control fields
`define ICR_GLOBAL_IRQ_ENABLE 7
`define ICR_OVERFLOW_IRQ_ENABLE 5
`define ICR_OVERFLOW_FLAG 2
`define ICR_RESET 8'h00

// Core control fields: sleep level, watchdog clear strobe
`define CORE_SLEEP 0
`define CORE_WATCHDOG_CLEAR 1

// Phase clocks: four clk cycles per instruction cycle
`define PHASES_PER_CYCLE 4
`define PHASE_Q2 2'h1
`define PHASE_Q4 2'h3
`define WRITE_HOLDOFF_CYCLES 2'h2
`define TIMER_COUNT_RESET 8'h00

`endif

/* File: logic/prescaler.v */
// Shared 8-bit prescaler with ratio tap selection
`timescale 1ns/1ps
module prescaler #(
   parameter WIDTH = 8
) (
   input wire clk,
   input wire rstn,
   input wire clear,
   input wire tick,
   input wire [2:0] tap,
   output reg tap_out
);

   reg [WIDTH-1:0] count_r;

   ////////////////////////////////////////////////////////////////////////////
   // Counter advances on each source tick; clear has priority
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= {WIDTH{1'b0}};
      end else if (clear) begin
         count_r <= {WIDTH{1'b0}};
      end else if (tick) begin
         count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   // Selected bit gives a symmetric divide by 2^(tap+1)
   always @* begin
      tap_out = count_r[tap];
   end

endmodule

/* File: logic/timer0.v */
// Timer/counter with shared prescaler behind an AHB-Lite register slave
`timescale 1ns/1ps
`include "timer0_defs.vh"
module timer0 (
   input wire clk,
   input wire rstn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire ext_count_pin,
   output wire overflow_irq,
   output wire watchdog_tick,
   output wire watchdog_clear,
   output wire sleep
);

   reg [7:0] timer_count_r;
   reg [7:0] timer_count_nxt;
   reg [7:0] interrupt_control_r;
   reg [7:0] timer_configuration_r;
   reg sleep_r;
   reg wdt_clear_r;
   reg [1:0] phase_r;
   reg [1:0] holdoff_r;
   reg pin_meta_r;
   reg pin_sync_r;
   reg samp_r;
   reg samp_prev_r;
   reg wr_pend_r;
   reg [11:0] wr_addr_r;
   reg [7:0] rd_sel;
   wire instr_tick;
   wire q_sample;
   wire src_level;
   wire src_edge;
   wire to_counter;
   wire presc_tick;
   wire presc_clear;
   wire presc_out;
   wire presc_out_src;
   wire [2:0] presc_tap;
   wire count_tick;
   wire count_write;
   wire addr_phase;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode, used by the read mux only; writes compare the latched address
   function [1:0] reg_sel;
      input [11:0] a;
      begin
         case (a)
            `ADDR_TIMER_COUNT: reg_sel = 2'h0;
            `ADDR_INTERRUPT_CONTROL: reg_sel = 2'h1;
            `ADDR_TIMER_CONFIGURATION: reg_sel = 2'h2;
            `ADDR_CORE_CONTROL: reg_sel = 2'h3;
            default: reg_sel = 2'h0;
         endcase
      end
   endfunction

   function hit;
      input [11:0] a;
      begin
         hit = (a == `ADDR_TIMER_COUNT) || (a == `ADDR_INTERRUPT_CONTROL) ||
            (a == `ADDR_TIMER_CONFIGURATION) || (a == `ADDR_CORE_CONTROL);
      end
   endfunction

   // Data-phase write strobe for one register; shared by every write path
   function wr_hit;
      input [11:0] a;
      begin
         wr_hit = wr_pend_r && (wr_addr_r == a);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait state, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_phase = hsel && hready && htrans[1];

   // Capture write address phase; data lands one cycle later
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
      end else begin
         wr_pend_r <= addr_phase && hwrite;
         wr_addr_r <= haddr[11:0];
      end
   end

   // Read mux; unmapped addresses and bits above bit 7 read zero
   always @* begin
      case (reg_sel(haddr[11:0]))
         2'h0: rd_sel = timer_count_r;
         2'h1: rd_sel = interrupt_control_r;
         2'h2: rd_sel = timer_configuration_r;
         default: rd_sel = {7'h00, sleep_r};
      endcase
      if (!hit(haddr[11:0])) begin
         rd_sel = 8'h00;
      end
   end

   // Read data registered at the address phase, valid in data phase
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hrdata <= 32'h00000000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= {24'h000000, rd_sel};
      end
   end

   // Write strobes land at the end of the data phase
   assign count_write = wr_hit(`ADDR_TIMER_COUNT);

   ////////////////////////////////////////////////////////////////////////////
   // Phase generator: four clk per instruction cycle, frozen in sleep
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase_r <= 2'h0;
      end else if (!sleep_r) begin
         phase_r <= phase_r + 2'h1;
      end
   end

   assign instr_tick = !sleep_r && (phase_r == `PHASE_Q4);
   assign q_sample = !sleep_r && ((phase_r == `PHASE_Q2) || (phase_r == `PHASE_Q4));

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser; pin must meet width limits to be seen
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta_r <= 1'b0;
         pin_sync_r <= 1'b0;
      end else begin
         pin_meta_r <= ext_count_pin;
         pin_sync_r <= pin_meta_r;
      end
   end

   // Edge select: inverting the pin makes the falling edge count
   assign src_level = pin_sync_r ^ timer_configuration_r[`CFG_SOURCE_EDGE_SELECT];
   assign to_counter = !timer_configuration_r[`CFG_PRESCALER_ASSIGNMENT];

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler source: external edges in counter mode while assigned to the counter, else instruction cycles
   // Starts high: no edge is seen until the source has been low once
   reg src_prev_r;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         src_prev_r <= 1'b1;
      end else begin
         src_prev_r <= src_level;
      end
   end

   assign src_edge = src_level && !src_prev_r && !sleep_r;
   // Watchdog postscaler counts instruction cycles; the pin never reaches it
   assign presc_tick = to_counter ?
      (timer_configuration_r[`CFG_CLOCK_SOURCE_SELECT] ? src_edge : instr_tick) :
      instr_tick;
   assign presc_clear = (to_counter && count_write) ||
      (!to_counter && wdt_clear_r);
   // Both tap bit n (2^(n+1)); watchdog counts both edges of it (2^n)
   assign presc_tap = timer_configuration_r[`CFG_RATIO_HI:`CFG_RATIO_LO];

   prescaler #(
      .WIDTH(8)
   ) u_prescaler (
      .clk(clk),
      .rstn(rstn),
      .clear(presc_clear),
      .tick(presc_tick),
      .tap(presc_tap),
      .tap_out(presc_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler output or raw source, resampled at Q2/Q4 only
   assign presc_out_src = to_counter ? presc_out :
      (timer_configuration_r[`CFG_CLOCK_SOURCE_SELECT] ? src_level : 1'b0);

   // Samples reset high: an idle pin seen inverted must not
   // look like a fresh edge when reset lifts
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         samp_r <= 1'b1;
         samp_prev_r <= 1'b1;
      end else if (q_sample) begin
         samp_r <= presc_out_src;
         samp_prev_r <= samp_r;
      end
   end

   // Count tick: sampled rising edge, or plain instruction cycle
   assign count_tick = (to_counter || timer_configuration_r[`CFG_CLOCK_SOURCE_SELECT]) ?
      (q_sample && samp_r && !samp_prev_r) :
      instr_tick;

   // Watchdog postscale: half of the counter tap gives 2^n
   reg wdt_prev_r;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wdt_prev_r <= 1'b0;
      end else begin
         wdt_prev_r <= presc_out;
      end
   end
   assign watchdog_tick = !to_counter && (presc_out != wdt_prev_r);
   assign watchdog_clear = wdt_clear_r;

   ////////////////////////////////////////////////////////////////////////////
   // Write holdoff: two instruction cycles after a count write
   // Counts down on instruction cycles only, so it also waits out sleep
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         holdoff_r <= 2'h0;
      end else if (count_write) begin
         holdoff_r <= `WRITE_HOLDOFF_CYCLES;
      end else if (instr_tick && holdoff_r != 2'h0) begin
         holdoff_r <= holdoff_r - 2'h1;
      end
   end

   // Count next value; write wins over increment
   always @* begin
      timer_count_nxt = timer_count_r;
      if (count_write) begin
         timer_count_nxt = hwdata[7:0];
      end else if (count_tick && holdoff_r == 2'h0 && !sleep_r) begin
         timer_count_nxt = timer_count_r + 8'h01;
      end
   end

   // Rollover uses the same qualifiers as the increment itself
   wire overflow_evt = !count_write && count_tick && holdoff_r == 2'h0 && !sleep_r &&
      timer_count_r == 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; hardware flag set wins over software clear
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         timer_count_r <= `TIMER_COUNT_RESET;
         interrupt_control_r <= `ICR_RESET;
         timer_configuration_r <= `CFG_RESET;
         sleep_r <= 1'b0;
         wdt_clear_r <= 1'b0;
      end else begin
         timer_count_r <= timer_count_nxt;
         wdt_clear_r <= 1'b0;
         if (wr_hit(`ADDR_INTERRUPT_CONTROL)) begin
            interrupt_control_r <= hwdata[7:0];
         end
         if (overflow_evt) begin
            interrupt_control_r[`ICR_OVERFLOW_FLAG] <= 1'b1;
         end
         if (wr_hit(`ADDR_TIMER_CONFIGURATION)) begin
            timer_configuration_r <= hwdata[7:0];
         end
         if (wr_hit(`ADDR_CORE_CONTROL)) begin
            sleep_r <= hwdata[`CORE_SLEEP];
            wdt_clear_r <= hwdata[`CORE_WATCHDOG_CLEAR];
         end
      end
   end

   // Request gated by enable; no wake path in sleep
   assign overflow_irq = interrupt_control_r[`ICR_OVERFLOW_FLAG] &&
      interrupt_control_r[`ICR_OVERFLOW_IRQ_ENABLE] &&
      interrupt_control_r[`ICR_GLOBAL_IRQ_ENABLE] && !sleep_r;
   assign sleep = sleep_r;

endmodule

/* File: bench/timer0_sva.sv */
// Checker for the timer block's bus answer, interrupt and core-control outputs
`timescale 1ns/1ps
`include "timer0_defs.vh"
module timer0_sva (
   input wire clk,
   input wire rstn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire overflow_irq,
   input wire watchdog_clear,
   input wire sleep
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   reg core_dp_r;
   reg icr_dp_r;
   reg [1:0] en_r;
   wire take;
   assign take = hsel && hready && htrans[1] && hwrite;
   ////////////////////////////////////////////////////////////////////////
   // Shadow of write data phases and of the two enables, as software set them
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         core_dp_r <= 1'b0;
         icr_dp_r <= 1'b0;
         en_r <= 2'h0;
      end else begin
         if (icr_dp_r)
            en_r <= {hwdata[7], hwdata[5]};
         core_dp_r <= take && haddr[11:0] == `ADDR_CORE_CONTROL;
         icr_dp_r <= take && haddr[11:0] == `ADDR_INTERRUPT_CONTROL;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_ready;
      hreadyout && !hresp;
   endproperty
   a_ready: assert property (p_ready) else $error("bus answer not ready or not okay");
   property p_mask;
      overflow_irq |-> en_r == 2'h3;
   endproperty
   a_mask: assert property (p_mask) else $error("request while masked");
   property p_sleep_irq;
      sleep |-> !overflow_irq;
   endproperty
   a_sleep_irq: assert property (p_sleep_irq) else $error("request during sleep");
   property p_sleep_src;
      !$stable(sleep) |-> $past(core_dp_r);
   endproperty
   a_sleep_src: assert property (p_sleep_src) else $error("sleep moved unasked");
   property p_clr_cause;
      $rose(watchdog_clear) |-> $past(core_dp_r) || $past(core_dp_r, 2);
   endproperty
   a_clr_cause: assert property (p_clr_cause) else $error("clear without write");
   property p_clr_pulse;
      watchdog_clear |=> !watchdog_clear;
   endproperty
   a_clr_pulse: assert property (p_clr_pulse) else $error("clear longer than one cycle");
   property p_clr_after;
      core_dp_r && hwdata[1] |-> ##[1:2] watchdog_clear;
   endproperty
   a_clr_after: assert property (p_clr_after) else $error("clear write lost");
   property p_irq_hold;
      overflow_irq && !icr_dp_r && !core_dp_r |=> overflow_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("flag dropped by itself");
   c_irq: cover property (overflow_irq);
   c_clr: cover property (watchdog_clear);
   c_sleep: cover property (sleep);
endmodule
bind timer0 timer0_sva u_timer0_sva (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hreadyout, .hresp, .overflow_irq, .watchdog_clear, .sleep);

/* File: bench/count_source.sv */
// Model of the external source driving the count pin
`timescale 1ns/1ps
module count_source (
   input wire clk,
   input wire level,
   input wire [3:0] lag,
   output reg pin
);
   reg [3:0] held_r;
   reg [3:0] wait_r;
   // Follow the asked level after lag cycles, never narrower than four clocks
   always @(posedge clk) begin
      held_r <= (held_r == 4'hf) ? held_r : held_r + 4'h1;
      if (level == pin)
         wait_r <= 4'h0;
      else if (wait_r >= lag && held_r >= 4'h4) begin
         pin <= level;
         held_r <= 4'h0;
         wait_r <= 4'h0;
      end else
         wait_r <= wait_r + 4'h1;
   end
   initial begin
      pin = 1'b0;
      held_r = 4'h0;
      wait_r = 4'h0;
   end
endmodule

/* File: bench/tb_timer0.sv */
// Self-checking bench for the timer block
`timescale 1ns/1ps
`include "timer0_defs.vh"
module tb_timer0;
   localparam [11:0] A_CNT = `ADDR_TIMER_COUNT;
   localparam [11:0] A_ICR = `ADDR_INTERRUPT_CONTROL;
   localparam [11:0] A_CFG = `ADDR_TIMER_CONFIGURATION;
   localparam [11:0] A_CORE = `ADDR_CORE_CONTROL;
   reg clk;
   reg rstn;
   reg hsel;
   reg [31:0] haddr;
   reg [1:0] htrans;
   reg hwrite;
   reg [2:0] hsize;
   reg [31:0] hwdata;
   reg level;
   reg [3:0] lag;
   reg irq_s;
   reg [31:0] rd;
   wire hreadyout;
   wire [31:0] hrdata;
   wire ext_count_pin;
   wire overflow_irq;
   wire watchdog_tick;
   wire watchdog_clear;
   wire sleep;
   integer n_fail = 0;
   integer comparisons = 0;
   integer cycles = 0;
   integer ticks = 0;
   integer clears = 0;
   integer t0;
   integer i;
   timer0 u_timer0 (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .ext_count_pin, .overflow_irq,
      .watchdog_tick, .watchdog_clear, .sleep);
   count_source u_count_source (.clk, .level, .lag, .pin(ext_count_pin));
   ////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Unknown counts as out of range
   task chk_in(input [31:0] v, input [31:0] lo, input [31:0] hi);
      chk(v, ((v >= lo && v <= hi) === 1'b1) ? v : lo);
   endtask
   // One single transfer; address held until ready, data taken at the second edge
   task ahb(input w, input [11:0] a, input [31:0] d);
      begin
         htrans <= 2'h2;
         haddr <= {20'h0, a};
         hwrite <= w;
         @(posedge clk);
         while (hreadyout !== 1'b1)
            @(posedge clk);
         htrans <= 2'h0;
         hwdata <= d;
         @(posedge clk);
         while (hreadyout !== 1'b1)
            @(posedge clk);
         rd = hrdata;
      end
   endtask
   task idle(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task complete_run;
      begin
         if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Reset values, read-back and an unmapped place
   task t_regs;
      begin
         ahb(0, A_CFG, 0);
         chk(rd, 32'hff);
         ahb(0, A_ICR, 0);
         chk(rd, 32'h0);
         ahb(1, 12'h100, 32'h5a);
         ahb(0, 12'h100, 0);
         chk(rd, 32'h0);
         ahb(1, A_CFG, 32'h3c);
         ahb(0, A_CNT, 0);
         chk(rd, 32'h0);
         ahb(0, A_CFG, 0);
         chk(rd, 32'h3c);
      end
   endtask
   // Instruction-cycle counting, two cycles lost after a count write
   task t_timer;
      begin
         ahb(1, A_CFG, 32'h08);
         ahb(1, A_CNT, 32'h10);
         idle(40);
         ahb(0, A_CNT, 0);
         chk_in(rd, 32'h17, 32'h19);
      end
   endtask
   // Every ratio code; four prescaled periods give three or four counts
   task t_ratio;
      for (i = 0; i < 8; i = i + 1) begin
         ahb(1, A_CFG, i);
         ahb(1, A_CNT, 0);
         idle(32 << i);
         ahb(0, A_CNT, 0);
         chk_in(rd, 3, 4);
      end
   endtask
   // Pin counting on the chosen edge, prompt or slow source
   task t_edge(input se);
      begin
         lag <= se ? 4'h5 : 4'h0;
         ahb(1, A_CFG, {26'h0, 1'b1, se, 4'h8});
         ahb(1, A_CNT, 0);
         idle(12);
         level <= 1'b1;
         ahb(0, A_CNT, 0);
         chk(rd, 32'h0);
         idle(20);
         ahb(0, A_CNT, 0);
         chk(rd, {31'h0, !se});
         level <= 1'b0;
         idle(20);
         ahb(0, A_CNT, 0);
         chk(rd, 32'h1);
      end
   endtask
   // Rollover sets the flag; masking hides the request but keeps the flag
   task t_ovf;
      begin
         ahb(1, A_CFG, 32'h08);
         ahb(1, A_ICR, 32'ha0);
         ahb(1, A_CNT, 32'hfe);
         idle(30);
         chk(irq_s, 1'b1);
         ahb(0, A_ICR, 0);
         chk(rd, 32'ha4);
         ahb(1, A_ICR, 32'h84);
         idle(2);
         chk(irq_s, 1'b0);
         ahb(0, A_ICR, 0);
         chk(rd, 32'h84);
         ahb(1, A_ICR, 32'h0);
      end
   endtask
   // Count frozen and request silent while asleep
   task t_sleep;
      begin
         ahb(1, A_ICR, 32'ha0);
         ahb(1, A_CNT, 32'hfe);
         ahb(1, A_CORE, 32'h1);
         idle(40);
         chk(irq_s, 1'b0);
         chk(sleep, 1'b1);
         ahb(0, A_CNT, 0);
         chk(rd, 32'hfe);
         ahb(1, A_CORE, 32'h0);
         idle(30);
         chk(irq_s, 1'b1);
         ahb(1, A_ICR, 32'h0);
      end
   endtask
   // Pin edges through the 1:2 prescaler: four rising edges give two counts
   task t_pscnt;
      begin
         ahb(1, A_CFG, 32'h20);
         ahb(1, A_CNT, 32'h0);
         idle(12);
         for (i = 0; i < 4; i = i + 1) begin
            level <= 1'b1;
            idle(12);
            level <= 1'b0;
            idle(12);
         end
         ahb(0, A_CNT, 0);
         chk(rd, 32'h2);
      end
   endtask
   // Watchdog ticks only while it owns the prescaler; handover in the safe order
   task t_wdog;
      begin
         ahb(1, A_CFG, 32'h00);
         idle(4);
         t0 = ticks;
         idle(100);
         chk(ticks - t0, 0);
         ahb(1, A_CNT, 32'h0);
         t0 = clears;
         ahb(1, A_CORE, 32'h2);
         idle(4);
         chk(clears - t0, 1);
         ahb(1, A_CFG, 32'h08);
         t0 = ticks;
         idle(100);
         chk_in(ticks - t0, 24, 27);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Inputs quiet at time zero, reset held twenty cycles
   initial begin
      rstn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      level = 1'b0;
      lag = 4'h0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      t_regs;
      t_timer;
      t_ratio;
      t_edge(1'b0);
      t_edge(1'b1);
      t_pscnt;
      t_ovf;
      t_sleep;
      t_wdog;
      complete_run;
   end
   // Pre-edge samples of outputs, and the hang limit
   always @(posedge clk) begin
      cycles = cycles + 1;
      irq_s <= overflow_irq;
      if (watchdog_tick === 1'b1)
         ticks = ticks + 1;
      if (watchdog_clear === 1'b1)
         clears = clears + 1;
      if (cycles == 30000) begin
         n_fail = n_fail + 1;
         complete_run;
      end
   end
endmodule
